/* File: design/pasl_consts.vh */
// Offsets, field positions, defaults and timing for the aux/indicator regs
`ifndef PASL_CONSTS_VH
`define PASL_CONSTS_VH

// =====================================================================
// Register indices (byte address is four times the index)
`define PASL_AUX_IDX 6'h1c
`define PASL_IND_IDX 6'h1d

// =====================================================================
// Auxiliary control/status field positions
`define PASL_AUX_ANC_BIT 15
`define PASL_AUX_AND_BIT 14
`define PASL_AUX_XOVER_BIT 13
`define PASL_AUX_CDSWAP_BIT 12
`define PASL_AUX_POL_HI 11
`define PASL_AUX_POL_LO 8
`define PASL_AUX_TO_MSB_BIT 7
`define PASL_AUX_LPEN_BIT 6
`define PASL_AUX_FDX_BIT 5
`define PASL_AUX_SPD_HI 4
`define PASL_AUX_SPD_LO 3
`define PASL_AUX_TO_LSB_BIT 2
`define PASL_AUX_MEDIA_HI 1
`define PASL_AUX_MEDIA_LO 0

// =====================================================================
// Fixed reset values of the non-strapped writable bits
`define PASL_LPEN_RST 1'b0
`define PASL_TO_LSB_RST 1'b0

// =====================================================================
// Bus answers
`define PASL_RESP_OKAY 2'h0
`define PASL_RESP_SLVERR 2'h2

// =====================================================================
// Timing: clock period and link-status timeouts
`define PASL_CLK_PERIOD_NS 100
`define PASL_LP_TO0_MS 2300
`define PASL_LP_TO1_MS 3300
`define PASL_LP_TO2_MS 4300
`define PASL_LP_TO3_MS 5300

`endif

/* File: design/pasl_ind_field.v */
// One sticky indicator mode field with extended-set resolution
module pasl_ind_field (
    input wire clk_sys_i,
    input wire rst_n_i,
    input wire [3:0] strap_i,
    input wire wr_en_i,
    input wire [3:0] wdata_i,
    input wire ext_en_i,
    output wire [3:0] mode_o,
    output wire [4:0] sel_o
);

    reg [3:0] mode_ff;
    reg [4:0] sel_ff;

    // =================================================================
    // Field storage
    // Only the hardware reset reloads the strap; no soft clear path
    always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            mode_ff <= strap_i;
        end else if (wr_en_i) begin
            mode_ff <= wdata_i;
        end
    end

    // =================================================================
    // Effective mode: top bit picks the extended set
    always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            sel_ff <= 5'h00;
        end else begin
            sel_ff <= {ext_en_i, mode_ff};
        end
    end

    assign mode_o = mode_ff;
    assign sel_o = sel_ff;

endmodule // pasl_ind_field

/* File: design/pasl_regs.v */
// Auxiliary status and indicator mode registers behind an AXI4-Lite slave
`include "pasl_consts.vh"

// How it works
// - Aux bit 15 reads back the negotiation-complete status input.
// - Aux bit 14 reads the inverse of the negotiation enable input.
// - Aux bit 13 reads 1 while the internal crossover is applied.
// - Aux bit 12 reads 1 while the C/D pair swap is applied.
// - Aux bits 11..8 flag inverted polarity on pairs A, B, C and D.
// - Aux bits 7 (MSB) and 2 pick a 2.3, 3.3, 4.3 or 5.3 s timeout.
// - Aux bit 6 enables low-power link mode and survives soft resets.
// - Aux bit 5 reads 1 for full duplex and 0 for half duplex.
// - Aux bits 4:3 report speed as 00 10M, 01 100M, 10 1000M.
// - Aux bits 1:0 report media as 00 none, 01 copper, 10 SerDes.
// - The mode register holds four 4-bit indicator fields, 3 down to 0.
// - Indicator fields keep their value across soft resets.
// - An extended-enable bit makes its indicator use the extended set.
module pasl_regs #(
    parameter [63:0] LP_TO0_CYC =
        (64'd1000000 * `PASL_LP_TO0_MS) / `PASL_CLK_PERIOD_NS,
    parameter [63:0] LP_TO1_CYC =
        (64'd1000000 * `PASL_LP_TO1_MS) / `PASL_CLK_PERIOD_NS,
    parameter [63:0] LP_TO2_CYC =
        (64'd1000000 * `PASL_LP_TO2_MS) / `PASL_CLK_PERIOD_NS,
    parameter [63:0] LP_TO3_CYC =
        (64'd1000000 * `PASL_LP_TO3_MS) / `PASL_CLK_PERIOD_NS
) (
    input wire clk_sys_i,
    input wire rst_n_i,
    // AXI4-Lite write address
    input wire [7:0] s_axi_awaddr_i,
    input wire s_axi_awvalid_i,
    output wire s_axi_awready_o,
    // AXI4-Lite write data
    input wire [31:0] s_axi_wdata_i,
    input wire [3:0] s_axi_wstrb_i,
    input wire s_axi_wvalid_i,
    output wire s_axi_wready_o,
    // AXI4-Lite write response
    output wire [1:0] s_axi_bresp_o,
    output wire s_axi_bvalid_o,
    input wire s_axi_bready_i,
    // AXI4-Lite read address
    input wire [7:0] s_axi_araddr_i,
    input wire s_axi_arvalid_i,
    output wire s_axi_arready_o,
    // AXI4-Lite read data
    output wire [31:0] s_axi_rdata_o,
    output wire [1:0] s_axi_rresp_o,
    output wire s_axi_rvalid_o,
    input wire s_axi_rready_i,
    // Resolved link state from the PHY core
    input wire an_complete_i,
    input wire an_enable_i,
    input wire crossover_i,
    input wire cd_swap_i,
    input wire [3:0] pol_inv_i,
    input wire full_duplex_flag_i,
    input wire [1:0] speed_i,
    input wire [1:0] media_i,
    // Straps: [15:0] indicator modes, [16] timeout MSB
    input wire [16:0] config_strap_pins_i,
    // Extended indicator-mode enables, one per indicator output
    input wire [3:0] ext_indicator_en_i,
    // Low-power link-status controls
    output wire lp_link_en_o,
    output wire [1:0] lp_timeout_sel_o,
    output wire [25:0] lp_timeout_cyc_o,
    // Effective mode per indicator: {extended, code}, output 0 lowest
    output wire [19:0] indicator_mode_o
);

    // =================================================================
    // Declarations
    reg awready_ff;
    reg nxt_awready;
    reg wready_ff;
    reg nxt_wready;
    reg bvalid_ff;
    reg nxt_bvalid;
    reg [1:0] bresp_ff;
    reg [1:0] nxt_bresp;
    reg arready_ff;
    reg nxt_arready;
    reg rvalid_ff;
    reg nxt_rvalid;
    reg [1:0] rresp_ff;
    reg [1:0] nxt_rresp;
    reg [31:0] rdata_ff;
    reg [31:0] nxt_rdata;

    reg [5:0] wr_idx_ff;
    reg [5:0] nxt_wr_idx;
    reg [15:0] wr_data_ff;
    reg [15:0] nxt_wr_data;
    reg [1:0] wr_strb_ff;
    reg [1:0] nxt_wr_strb;

    reg to_msb_ff;
    reg to_lsb_ff;
    reg lp_en_ff;
    reg [25:0] lp_cyc_ff;
    reg [25:0] nxt_lp_cyc;

    wire aw_take;
    wire w_take;
    wire wr_fire;
    wire wr_aux;
    wire wr_ind;
    wire ar_take;
    wire [5:0] rd_idx;
    wire [15:0] aux_rd;
    wire [15:0] ind_rd;
    wire [19:0] ind_sel;

    // =================================================================
    // Handshakes
    assign aw_take = s_axi_awvalid_i && awready_ff;
    assign w_take = s_axi_wvalid_i && wready_ff;
    // Both halves held and no answer pending: commit this cycle
    assign wr_fire = !awready_ff && !wready_ff && !bvalid_ff;
    assign wr_aux = wr_fire && (wr_idx_ff == `PASL_AUX_IDX);
    assign wr_ind = wr_fire && (wr_idx_ff == `PASL_IND_IDX);
    assign ar_take = s_axi_arvalid_i && arready_ff;
    assign rd_idx = s_axi_araddr_i[7:2];

    // =================================================================
    // Write channel: address and data taken in either order
    always @* begin
        nxt_awready = awready_ff;
        nxt_wready = wready_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp = bresp_ff;
        nxt_wr_idx = wr_idx_ff;
        nxt_wr_data = wr_data_ff;
        nxt_wr_strb = wr_strb_ff;
        if (aw_take) begin
            nxt_awready = 1'b0;
            nxt_wr_idx = s_axi_awaddr_i[7:2];
        end
        if (w_take) begin
            nxt_wready = 1'b0;
            nxt_wr_data = s_axi_wdata_i[15:0];
            nxt_wr_strb = s_axi_wstrb_i[1:0];
        end
        if (wr_fire) begin
            nxt_bvalid = 1'b1;
            if (wr_aux || wr_ind) begin
                nxt_bresp = `PASL_RESP_OKAY;
            end else begin
                nxt_bresp = `PASL_RESP_SLVERR;
            end
        end
        // Ready again only once the answer is taken: one write at a time
        if (bvalid_ff && s_axi_bready_i) begin
            nxt_bvalid = 1'b0;
            nxt_awready = 1'b1;
            nxt_wready = 1'b1;
        end
    end

    always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
            bvalid_ff <= 1'b0;
            bresp_ff <= `PASL_RESP_OKAY;
            wr_idx_ff <= 6'h00;
            wr_data_ff <= 16'h0000;
            wr_strb_ff <= 2'h0;
        end else begin
            awready_ff <= nxt_awready;
            wready_ff <= nxt_wready;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
            wr_idx_ff <= nxt_wr_idx;
            wr_data_ff <= nxt_wr_data;
            wr_strb_ff <= nxt_wr_strb;
        end
    end

    // =================================================================
    // Auxiliary register writable bits
    // Status bits have no storage here, so writes cannot touch them
    always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            to_msb_ff <= config_strap_pins_i[16];
            to_lsb_ff <= `PASL_TO_LSB_RST;
            lp_en_ff <= `PASL_LPEN_RST;
        end else if (wr_aux) begin
            if (wr_strb_ff[0]) begin
                // Only bits 7, 6 and 2 are stored
                to_msb_ff <= wr_data_ff[`PASL_AUX_TO_MSB_BIT];
                lp_en_ff <= wr_data_ff[`PASL_AUX_LPEN_BIT];
                to_lsb_ff <= wr_data_ff[`PASL_AUX_TO_LSB_BIT];
            end
        end
    end

    // =================================================================
    // Timeout selection in clock cycles
    always @* begin
        case ({to_msb_ff, to_lsb_ff})
            2'b00: nxt_lp_cyc = LP_TO0_CYC[25:0];
            2'b01: nxt_lp_cyc = LP_TO1_CYC[25:0];
            2'b10: nxt_lp_cyc = LP_TO2_CYC[25:0];
            2'b11: nxt_lp_cyc = LP_TO3_CYC[25:0];
            default: nxt_lp_cyc = LP_TO0_CYC[25:0];
        endcase
    end

    always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            lp_cyc_ff <= 26'h000_0000;
        end else begin
            lp_cyc_ff <= nxt_lp_cyc;
        end
    end

    // =================================================================
    // Indicator mode fields
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_ind
            pasl_ind_field u_field (
                .clk_sys_i(clk_sys_i),
                .rst_n_i(rst_n_i),
                .strap_i(config_strap_pins_i[4*gi+3:4*gi]),
                .wr_en_i(wr_ind && wr_strb_ff[gi/2]),
                .wdata_i(wr_data_ff[4*gi+3:4*gi]),
                .ext_en_i(ext_indicator_en_i[gi]),
                .mode_o(ind_rd[4*gi+3:4*gi]),
                .sel_o(ind_sel[5*gi+4:5*gi])
            );
        end
    endgenerate

    // =================================================================
    // Read view of the auxiliary register
    assign aux_rd[`PASL_AUX_ANC_BIT] = an_complete_i;
    assign aux_rd[`PASL_AUX_AND_BIT] = ~an_enable_i;
    assign aux_rd[`PASL_AUX_XOVER_BIT] = crossover_i;
    assign aux_rd[`PASL_AUX_CDSWAP_BIT] = cd_swap_i;
    // Pair A lands on the highest bit
    assign aux_rd[`PASL_AUX_POL_HI:`PASL_AUX_POL_LO] =
        {pol_inv_i[0], pol_inv_i[1], pol_inv_i[2], pol_inv_i[3]};
    assign aux_rd[`PASL_AUX_TO_MSB_BIT] = to_msb_ff;
    assign aux_rd[`PASL_AUX_LPEN_BIT] = lp_en_ff;
    assign aux_rd[`PASL_AUX_FDX_BIT] = full_duplex_flag_i;
    assign aux_rd[`PASL_AUX_SPD_HI:`PASL_AUX_SPD_LO] = speed_i;
    assign aux_rd[`PASL_AUX_TO_LSB_BIT] = to_lsb_ff;
    assign aux_rd[`PASL_AUX_MEDIA_HI:`PASL_AUX_MEDIA_LO] = media_i;

    // =================================================================
    // Read channel: data one cycle after the address is taken
    always @* begin
        nxt_arready = arready_ff;
        nxt_rvalid = rvalid_ff;
        nxt_rresp = rresp_ff;
        nxt_rdata = rdata_ff;
        if (ar_take) begin
            nxt_arready = 1'b0;
            nxt_rvalid = 1'b1;
            case (rd_idx)
                `PASL_AUX_IDX: begin
                    nxt_rdata = {16'h0000, aux_rd};
                    nxt_rresp = `PASL_RESP_OKAY;
                end
                `PASL_IND_IDX: begin
                    nxt_rdata = {16'h0000, ind_rd};
                    nxt_rresp = `PASL_RESP_OKAY;
                end
                default: begin
                    nxt_rdata = 32'h0000_0000;
                    nxt_rresp = `PASL_RESP_SLVERR;
                end
            endcase
        end
        if (rvalid_ff && s_axi_rready_i) begin
            nxt_rvalid = 1'b0;
            nxt_arready = 1'b1;
        end
    end

    always @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rresp_ff <= `PASL_RESP_OKAY;
            rdata_ff <= 32'h0000_0000;
        end else begin
            arready_ff <= nxt_arready;
            rvalid_ff <= nxt_rvalid;
            rresp_ff <= nxt_rresp;
            rdata_ff <= nxt_rdata;
        end
    end

    // =================================================================
    // Outputs
    assign s_axi_awready_o = awready_ff;
    assign s_axi_wready_o = wready_ff;
    assign s_axi_bvalid_o = bvalid_ff;
    assign s_axi_bresp_o = bresp_ff;
    assign s_axi_arready_o = arready_ff;
    assign s_axi_rvalid_o = rvalid_ff;
    assign s_axi_rresp_o = rresp_ff;
    assign s_axi_rdata_o = rdata_ff;
    assign lp_link_en_o = lp_en_ff;
    assign lp_timeout_sel_o = {to_msb_ff, to_lsb_ff};
    assign lp_timeout_cyc_o = lp_cyc_ff;
    assign indicator_mode_o = ind_sel;

endmodule // pasl_regs

/* File: dv/pasl_regs_props.sv */
// Checker for the aux status and indicator mode register bank
module pasl_regs_props #(
    parameter [63:0] LP_TO0_CYC = 64'h000a,
    parameter [63:0] LP_TO1_CYC = 64'h0014,
    parameter [63:0] LP_TO2_CYC = 64'h001e,
    parameter [63:0] LP_TO3_CYC = 64'h0028
) (
    input wire clk_sys_i,
    input wire rst_n_i,
    input wire s_axi_awvalid_i,
    input wire s_axi_awready_o,
    input wire s_axi_wvalid_i,
    input wire s_axi_wready_o,
    input wire [1:0] s_axi_bresp_o,
    input wire s_axi_bvalid_o,
    input wire s_axi_bready_i,
    input wire s_axi_arvalid_i,
    input wire s_axi_arready_o,
    input wire [31:0] s_axi_rdata_o,
    input wire s_axi_rvalid_o,
    input wire s_axi_rready_i,
    input wire [3:0] ext_indicator_en_i,
    input wire lp_link_en_o,
    input wire [1:0] lp_timeout_sel_o,
    input wire [25:0] lp_timeout_cyc_o,
    input wire [19:0] indicator_mode_o
);
    // =================================================================
    // Helpers
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    function automatic logic [25:0] cyc_of(input logic [1:0] s);
        return s == 2'h0 ? LP_TO0_CYC[25:0] : s == 2'h1 ? LP_TO1_CYC[25:0] :
            s == 2'h2 ? LP_TO2_CYC[25:0] : LP_TO3_CYC[25:0];
    endfunction
    wire [3:0] ext_seen = {indicator_mode_o[19], indicator_mode_o[14],
        indicator_mode_o[9], indicator_mode_o[4]};

    // =================================================================
    // Bus timing
    a_write_answer: assert property (
        s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i &&
        s_axi_wready_o |-> ##2 s_axi_bvalid_o) else $error("write unanswered");
    a_read_answer: assert property (
        s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o &&
        !s_axi_arready_o) else $error("read unanswered");
    a_bresp_holds: assert property (
        s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o &&
        $stable(s_axi_bresp_o)) else $error("write response dropped");
    a_rdata_holds: assert property (
        s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o &&
        $stable(s_axi_rdata_o)) else $error("read data dropped");
    a_rdata_upper: assert property (
        s_axi_rvalid_o |-> s_axi_rdata_o[31:16] == 16'h0000)
        else $error("upper read data not zero");
    a_ready_blocked: assert property (
        s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
        else $error("write ready during response");

    // =================================================================
    // Control outputs
    a_lp_cycles: assert property (
        $past(rst_n_i) && $past(rst_n_i, 2) |->
        lp_timeout_cyc_o == cyc_of($past(lp_timeout_sel_o)))
        else $error("timeout count wrong");
    a_ext_mode: assert property (
        $past(rst_n_i) && $past(rst_n_i, 2) |->
        ext_seen == $past(ext_indicator_en_i)) else $error("ext mode wrong");
    // Only a completed write may move the sticky controls
    a_cfg_sticky: assert property (
        $changed({lp_link_en_o, lp_timeout_sel_o}) |-> $rose(s_axi_bvalid_o))
        else $error("control changed without write");

    c_slverr: cover property (s_axi_bvalid_o && s_axi_bresp_o == 2'h2);
    c_read: cover property (s_axi_rvalid_o && s_axi_rready_i);
    c_lp_on: cover property ($rose(lp_link_en_o));
endmodule // pasl_regs_props

bind pasl_regs pasl_regs_props #(
    .LP_TO0_CYC(LP_TO0_CYC),
    .LP_TO1_CYC(LP_TO1_CYC),
    .LP_TO2_CYC(LP_TO2_CYC),
    .LP_TO3_CYC(LP_TO3_CYC)
) u_props (
    .clk_sys_i, .rst_n_i, .s_axi_awvalid_i, .s_axi_awready_o,
    .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
    .s_axi_bready_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
    .s_axi_rvalid_o, .s_axi_rready_i, .ext_indicator_en_i, .lp_link_en_o,
    .lp_timeout_sel_o, .lp_timeout_cyc_o, .indicator_mode_o
);

/* File: dv/pasl_regs_tb.sv */
// Self-checking bench for the aux status and indicator mode registers
`include "pasl_consts.vh"
`define CHK(g, e) begin \
    checks_done++; \
    if ((g) !== (e)) begin \
        err_total++; \
        $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); \
    end \
end

module pasl_regs_tb;
    timeunit 1ns;
    timeprecision 1ns;
    // Short timeouts keep the count checks cheap
    localparam logic [63:0] TO0 = 64'h000a;
    localparam logic [63:0] TO1 = 64'h0014;
    localparam logic [63:0] TO2 = 64'h001e;
    localparam logic [63:0] TO3 = 64'h0028;
    int err_total = 0;
    int checks_done = 0;
    logic clk_sys_i = 1'b0, rst_n_i = 1'b0;
    logic [7:0] s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
    logic [31:0] s_axi_wdata_i = 32'h0000_0000;
    logic [3:0] s_axi_wstrb_i = 4'h0, pol_inv_i = 4'h0;
    logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0;
    logic s_axi_bready_i = 1'b0, s_axi_arvalid_i = 1'b0;
    logic s_axi_rready_i = 1'b0, an_complete_i = 1'b0, an_enable_i = 1'b0;
    logic crossover_i = 1'b0, cd_swap_i = 1'b0, full_duplex_flag_i = 1'b0;
    logic [1:0] speed_i = 2'h0, media_i = 2'h0;
    logic [16:0] config_strap_pins_i = 17'h0_0000;
    logic [3:0] ext_indicator_en_i = 4'h0;
    logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
    logic s_axi_rvalid_o, lp_link_en_o;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o, lp_timeout_sel_o;
    logic [31:0] s_axi_rdata_o;
    logic [25:0] lp_timeout_cyc_o;
    logic [19:0] indicator_mode_o;
    logic [15:0] m_aux, m_ind;

    pasl_regs #(
        .LP_TO0_CYC(TO0),
        .LP_TO1_CYC(TO1),
        .LP_TO2_CYC(TO2),
        .LP_TO3_CYC(TO3)
    ) dut_u (.*);

    initial begin
        forever #50 clk_sys_i = ~clk_sys_i;
    end

    // =================================================================
    // Expectations
    function automatic logic [25:0] cyc_of(input logic [1:0] s);
        return s == 2'h0 ? TO0[25:0] : s == 2'h1 ? TO1[25:0] :
            s == 2'h2 ? TO2[25:0] : TO3[25:0];
    endfunction
    function automatic logic [15:0] mrg(input logic [15:0] o,
        input logic [31:0] d, input logic [3:0] s);
        return {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
    endfunction
    function automatic logic [1:0] rsp_of(input logic [7:0] a);
        return (a[7:2] == `PASL_AUX_IDX || a[7:2] == `PASL_IND_IDX) ?
            `PASL_RESP_OKAY : `PASL_RESP_SLVERR;
    endfunction
    function automatic logic [31:0] rd_of(input logic [7:0] a);
        if (a[7:2] == `PASL_IND_IDX) return {16'h0000, m_ind};
        if (a[7:2] != `PASL_AUX_IDX) return 32'h0000_0000;
        return {16'h0000, an_complete_i, ~an_enable_i, crossover_i,
            cd_swap_i, pol_inv_i[0], pol_inv_i[1], pol_inv_i[2],
            pol_inv_i[3], m_aux[7:6], full_duplex_flag_i, speed_i,
            m_aux[2], media_i};
    endfunction
    function automatic logic [19:0] ind_of();
        logic [19:0] v;
        for (int i = 0; i < 4; i++) begin
            v[5*i +: 5] = {ext_indicator_en_i[i], m_ind[4*i +: 4]};
        end
        return v;
    endfunction

    // =================================================================
    // Bus and stimulus tasks
    task automatic axw(input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s);
        logic pa, pw, ta, tw;
        logic [1:0] r;
        pa = 1'b1;
        pw = 1'b1;
        @(posedge clk_sys_i);
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= d;
        s_axi_wstrb_i <= s;
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i <= 1'b1;
        s_axi_bready_i <= 1'b1;
        while (pa || pw) begin
            @(negedge clk_sys_i);
            ta = s_axi_awready_o;
            tw = s_axi_wready_o;
            @(posedge clk_sys_i);
            pa = pa && !ta;
            pw = pw && !tw;
            s_axi_awvalid_i <= pa;
            s_axi_wvalid_i <= pw;
        end
        do @(negedge clk_sys_i); while (!s_axi_bvalid_o);
        r = s_axi_bresp_o;
        @(posedge clk_sys_i);
        s_axi_bready_i <= 1'b0;
        `CHK(r, rsp_of(a))
        if (a[7:2] == `PASL_AUX_IDX) m_aux = mrg(m_aux, d, s);
        if (a[7:2] == `PASL_IND_IDX) m_ind = mrg(m_ind, d, s);
    endtask

    task automatic chk_rd(input logic [7:0] a);
        logic [31:0] d;
        logic [1:0] r;
        @(posedge clk_sys_i);
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1'b1;
        s_axi_rready_i <= 1'b1;
        do @(negedge clk_sys_i); while (!s_axi_arready_o);
        @(posedge clk_sys_i);
        s_axi_arvalid_i <= 1'b0;
        do @(negedge clk_sys_i); while (!s_axi_rvalid_o);
        d = s_axi_rdata_o;
        r = s_axi_rresp_o;
        @(posedge clk_sys_i);
        s_axi_rready_i <= 1'b0;
        `CHK(r, rsp_of(a))
        `CHK(d, rd_of(a))
        @(negedge clk_sys_i);
        `CHK(lp_link_en_o, m_aux[6])
        `CHK(lp_timeout_sel_o, {m_aux[7], m_aux[2]})
        `CHK(lp_timeout_cyc_o, cyc_of({m_aux[7], m_aux[2]}))
        `CHK(indicator_mode_o, ind_of())
    endtask

    task automatic do_reset();
        @(posedge clk_sys_i);
        rst_n_i <= 1'b0;
        config_strap_pins_i <= 17'($urandom);
        repeat (2) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        m_ind = config_strap_pins_i[15:0];
        m_aux = {8'h00, config_strap_pins_i[16], 7'h00};
    endtask

    task automatic rnd_op();
        logic [7:0] a;
        int k;
        {an_complete_i, an_enable_i, crossover_i, cd_swap_i, pol_inv_i,
            full_duplex_flag_i, speed_i, media_i,
            ext_indicator_en_i} <= 17'($urandom);
        k = $urandom % 8;
        a = k < 3 ? 8'h70 : k < 6 ? 8'h74 : {6'($urandom), 2'b00};
        if (k[0]) axw(a, $urandom, 4'($urandom));
        else chk_rd(a);
    endtask

    task automatic complete_run();
        if (err_total == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // =================================================================
    // Main sequence and watchdog
    initial begin
        int s;
        s = $urandom(32'h0000_26e4);
        do_reset();
        chk_rd(8'h70);
        chk_rd(8'h74);
        axw(8'h70, 32'hffff_ffff, 4'hf);
        chk_rd(8'h70);
        axw(8'h74, 32'h0000_a5c3, 4'h2);
        chk_rd(8'h74);
        axw(8'h7c, 32'hffff_ffff, 4'hf);
        chk_rd(8'h00);
        repeat (300) rnd_op();
        do_reset();
        chk_rd(8'h74);
        repeat (100) rnd_op();
        complete_run();
    end

    // Roughly seven times the expected run length
    initial begin
        #1_000_000;
        err_total++;
        complete_run();
    end
endmodule // pasl_regs_tb
